/* File: rtl/slfrc_prediv.sv */
// module: reference predivider counter
`timescale 1ns/100ps
`default_nettype none
module slfrc_prediv (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst,
	// setting and pulse
	slfrc_div_if.div   dv
);
	logic [4:0] cnt_q;
	logic [4:0] limit_q;
	logic       pulse_q;
	logic [4:0] eff_d;

	// codes 0 and 1 both mean divide-by-one
	always_comb begin
		eff_d = (dv.ratio < slfrc_pkg::PREDIV_ONE) ? slfrc_pkg::PREDIV_ONE : dv.ratio;
	end

	// new ratio loaded only when a cycle of the old one ends, so no runt period
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q   <= 5'h00;
			limit_q <= slfrc_pkg::PREDIV_ONE;
			pulse_q <= 1'b0;
		end else if (cnt_q + 5'h01 >= limit_q) begin
			cnt_q   <= 5'h00;
			limit_q <= eff_d;
			pulse_q <= 1'b1;
		end else begin
			cnt_q   <= cnt_q + 5'h01;
			pulse_q <= 1'b0;
		end
	end

	assign dv.pulse = pulse_q;
endmodule : slfrc_prediv
`default_nettype wire

/* File: rtl/slfrc_top.sv */
// module: loop filter and predivider configuration bank
`timescale 1ns/100ps
`default_nettype none
module slfrc_top (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// serial port register access
	input  wire logic [9:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output var  logic [7:0]  reg_rdata,
	// analog settings
	output var  logic [1:0]  second_pole_resistor,
	output var  logic [2:0]  zero_resistor,
	output var  logic [2:0]  first_pole_capacitor,
	output var  logic        zero_bypass,
	output var  logic [11:0] second_pole_ohms,
	output var  logic [11:0] zero_ohms,
	output var  logic [5:0]  first_pole_pf,
	// divided reference
	output var  logic        synth_ref_predivider_pulse
);
	logic [7:0] comp_q;
	logic [7:0] byp_q;
	logic [7:0] prediv_q;
	logic [7:0] rdata_d;
	logic [2:0] hit_d;
	logic [2:0] wen_d;
	slfrc_div_if dv ();

	// one-hot positions of the mapped registers
	localparam int HIT_COMP   = 0;
	localparam int HIT_BYPASS = 1;
	localparam int HIT_PREDIV = 2;

	// ****************************************************************************
	// address decode
	// ****************************************************************************
	// full ten-bit compare, so no unmapped address aliases onto a register
	function automatic logic [2:0] reg_hit(input logic [9:0] addr);
		case (addr)
			slfrc_pkg::OFF_COMPONENT_SELECT: reg_hit = 3'h1;
			slfrc_pkg::OFF_ZERO_BYPASS:      reg_hit = 3'h2;
			slfrc_pkg::OFF_PREDIVIDER:       reg_hit = 3'h4;
			default:                         reg_hit = 3'h0;
		endcase
	endfunction : reg_hit

	always_comb begin
		hit_d = reg_hit(reg_addr);
	end

	// writes to unmapped addresses fall out here and are dropped
	always_comb begin
		wen_d = reg_wr ? hit_d : 3'h0;
	end

	// ****************************************************************************
	// component select register
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			comp_q <= slfrc_pkg::RST_COMPONENT_SELECT;
		end else if (wen_d[HIT_COMP]) begin
			comp_q <= reg_wdata;
		end
	end

	// ****************************************************************************
	// zero bypass register
	// ****************************************************************************
	// reserved bits are never stored, so they always read back as zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			byp_q <= slfrc_pkg::RST_ZERO_BYPASS;
		end else if (wen_d[HIT_BYPASS]) begin
			byp_q <= reg_wdata & slfrc_pkg::BYPASS_MASK;
		end
	end

	// ****************************************************************************
	// predivider register
	// ****************************************************************************
	// the divider picks a new value up only at its next period boundary
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prediv_q <= slfrc_pkg::RST_PREDIVIDER;
		end else if (wen_d[HIT_PREDIV]) begin
			prediv_q <= reg_wdata & slfrc_pkg::PREDIV_MASK;
		end
	end

	// ****************************************************************************
	// readback mux
	// ****************************************************************************
	always_comb begin
		case (hit_d)
			3'h1:    rdata_d = comp_q;
			3'h2:    rdata_d = byp_q;
			3'h4:    rdata_d = prediv_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// ****************************************************************************
	// read data register
	// ****************************************************************************
	// holds the last read value; a write in the same cycle shows on the next read
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// ****************************************************************************
	// second-pole resistor code
	// ****************************************************************************
	// codes registered beside their decoded values, so both change together
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			second_pole_resistor <= 2'h0;
		end else begin
			second_pole_resistor <= comp_q[slfrc_pkg::POLE2_MSB:slfrc_pkg::POLE2_LSB];
		end
	end

	// ****************************************************************************
	// zero resistor code
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			zero_resistor <= 3'h0;
		end else begin
			zero_resistor <= comp_q[slfrc_pkg::ZERO_MSB:slfrc_pkg::ZERO_LSB];
		end
	end

	// ****************************************************************************
	// first-pole capacitor code
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			first_pole_capacitor <= 3'h0;
		end else begin
			first_pole_capacitor <= comp_q[slfrc_pkg::CAP_MSB:slfrc_pkg::CAP_LSB];
		end
	end

	// ****************************************************************************
	// zero bypass flag
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			zero_bypass <= 1'b0;
		end else begin
			zero_bypass <= byp_q[slfrc_pkg::BYPASS_BIT];
		end
	end

	// ****************************************************************************
	// second-pole resistance
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			second_pole_ohms <= 12'h000;
		end else begin
			second_pole_ohms <= slfrc_pkg::pole2_ohms(
				comp_q[slfrc_pkg::POLE2_MSB:slfrc_pkg::POLE2_LSB]);
		end
	end

	// ****************************************************************************
	// zero resistance
	// ****************************************************************************
	// bypass forces zero ohms; board must then fit the series resistor
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			zero_ohms <= 12'h000;
		end else begin
			zero_ohms <= byp_q[slfrc_pkg::BYPASS_BIT] ? 12'h000 :
				slfrc_pkg::zero_ohms(comp_q[slfrc_pkg::ZERO_MSB:slfrc_pkg::ZERO_LSB]);
		end
	end

	// ****************************************************************************
	// first-pole capacitance
	// ****************************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			first_pole_pf <= 6'h00;
		end else begin
			first_pole_pf <= slfrc_pkg::cap_pf(
				comp_q[slfrc_pkg::CAP_MSB:slfrc_pkg::CAP_LSB]);
		end
	end

	// ****************************************************************************
	// predivider
	// ****************************************************************************
	assign dv.ratio = prediv_q[slfrc_pkg::PREDIV_MSB:0];

	slfrc_prediv i_slfrc_prediv (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dv      (dv)
	);

	// ****************************************************************************
	// divided reference output
	// ****************************************************************************
	// one more flop so the top output comes straight from a register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			synth_ref_predivider_pulse <= 1'b0;
		end else begin
			synth_ref_predivider_pulse <= dv.pulse;
		end
	end
endmodule : slfrc_top
`default_nettype wire

/* File: shared/slfrc_div_if.sv */
// interface: predivider setting and pulse between config bank and divider
`timescale 1ns/100ps
`default_nettype none
interface slfrc_div_if;
	logic [4:0] ratio;
	logic       pulse;
	modport cfg (output ratio, input pulse);
	modport div (input ratio, output pulse);
endinterface : slfrc_div_if
`default_nettype wire

/* File: shared/slfrc_pkg.sv */
// package: offsets, fields, reset values and decode helpers for the loop filter config bank
// ****************************************************************************
// Contract
// - bits 7:6 pick second-pole resistor 900..225
// - bits 5:3 pick zero resistor per table
// - bits 2:0 pick first-pole capacitor 0..48pF
// - bypass bit zeroes zero resistor; external one needed
// - predivider 1..31, codes 0 and 1 divide-by-one
// ****************************************************************************
`default_nettype none
package slfrc_pkg;
	localparam logic [9:0] OFF_COMPONENT_SELECT = 10'h0F5;
	localparam logic [9:0] OFF_ZERO_BYPASS      = 10'h0F6;
	localparam logic [9:0] OFF_PREDIVIDER       = 10'h0F7;
	localparam int POLE2_MSB = 7;
	localparam int POLE2_LSB = 6;
	localparam int ZERO_MSB  = 5;
	localparam int ZERO_LSB  = 3;
	localparam int CAP_MSB   = 2;
	localparam int CAP_LSB   = 0;
	localparam int BYPASS_BIT = 0;
	localparam int PREDIV_MSB = 4;
	localparam logic [7:0] RST_COMPONENT_SELECT = 8'h00;
	localparam logic [7:0] RST_ZERO_BYPASS      = 8'h00;
	localparam logic [7:0] RST_PREDIVIDER       = 8'h00;
	localparam logic [7:0] BYPASS_MASK          = 8'h01;
	localparam logic [7:0] PREDIV_MASK          = 8'h1F;
	localparam logic [4:0] PREDIV_ONE           = 5'h01;

	// ohms for the second-pole resistor
	function automatic logic [11:0] pole2_ohms(input logic [1:0] code);
		case (code)
			2'h0: pole2_ohms = 12'h384;
			2'h1: pole2_ohms = 12'h1C2;
			2'h2: pole2_ohms = 12'h12C;
			default: pole2_ohms = 12'h0E1;
		endcase
	endfunction : pole2_ohms

	// ohms for the zero resistor; table is not monotonic
	function automatic logic [11:0] zero_ohms(input logic [2:0] code);
		case (code)
			3'h0: zero_ohms = 12'hCB2;
			3'h1: zero_ohms = 12'hABE;
			3'h2: zero_ohms = 12'h8CA;
			3'h3: zero_ohms = 12'h834;
			3'h4: zero_ohms = 12'hBB8;
			3'h5: zero_ohms = 12'h9C4;
			3'h6: zero_ohms = 12'h7D0;
			default: zero_ohms = 12'h73A;
		endcase
	endfunction : zero_ohms

	// picofarads for the first-pole capacitor; codes 3 and 4 coincide
	function automatic logic [5:0] cap_pf(input logic [2:0] code);
		case (code)
			3'h0: cap_pf = 6'h00;
			3'h1: cap_pf = 6'h08;
			3'h2: cap_pf = 6'h10;
			3'h3: cap_pf = 6'h18;
			3'h4: cap_pf = 6'h18;
			3'h5: cap_pf = 6'h20;
			3'h6: cap_pf = 6'h28;
			default: cap_pf = 6'h30;
		endcase
	endfunction : cap_pf
endpackage : slfrc_pkg
`default_nettype wire

/* File: sim/slfrc_top_sva.sv */
// checker: port-level properties of the loop filter config bank
`timescale 1ns/100ps
`default_nettype none
module slfrc_top_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register access
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// settings
	input wire logic [1:0] second_pole_resistor,
	input wire logic [2:0] zero_resistor,
	input wire logic [2:0] first_pole_capacitor,
	input wire logic zero_bypass,
	input wire logic [11:0] second_pole_ohms,
	input wire logic [11:0] zero_ohms,
	input wire logic [5:0] first_pole_pf,
	input wire logic synth_ref_predivider_pulse
);
	localparam logic [11:0] P2 [4] = '{12'h384,12'h1C2,12'h12C,12'h0E1};
	localparam logic [11:0] ZR [8] = '{12'hCB2,12'hABE,12'h8CA,12'h834,12'hBB8,12'h9C4,12'h7D0,12'h73A};
	localparam logic [5:0] CP [8] = '{6'h00,6'h08,6'h10,6'h18,6'h18,6'h20,6'h28,6'h30};
	logic w5;
	logic [5:0] gap_q;
	assign w5 = reg_wr && reg_addr == 10'h0F5;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// cycles since last pulse; a stuck divider overflows the bound
	always_ff @(posedge ref_clk) gap_q <= (rst || synth_ref_predivider_pulse) ? 6'h01 : gap_q + 6'h01;
	property p_pole;
		w5 |-> ##2 second_pole_resistor == $past(reg_wdata[7:6], 2)
			&& second_pole_ohms == P2[$past(reg_wdata[7:6], 2)];
	endproperty
	a_pole: assert property (p_pole) else $error("pole");
	property p_zero;
		w5 |-> ##2 zero_resistor == $past(reg_wdata[5:3], 2)
			&& (zero_bypass || zero_ohms == ZR[$past(reg_wdata[5:3], 2)]);
	endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_cap;
		w5 |-> ##2 first_pole_capacitor == $past(reg_wdata[2:0], 2)
			&& first_pole_pf == CP[$past(reg_wdata[2:0], 2)];
	endproperty
	a_cap: assert property (p_cap) else $error("cap");
	property p_byp;
		reg_wr && reg_addr == 10'h0F6 && reg_wdata[0] |-> ##2 zero_bypass && zero_ohms == 12'h000;
	endproperty
	a_byp: assert property (p_byp) else $error("bypass");
	property p_unm;
		reg_rd && !(reg_addr inside {10'h0F5, 10'h0F6, 10'h0F7}) |=> reg_rdata == 8'h00;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_rsv6;
		reg_rd && reg_addr == 10'h0F6 |=> reg_rdata[7:1] == 7'h00;
	endproperty
	a_rsv6: assert property (p_rsv6) else $error("rsv6");
	property p_rsv7;
		reg_rd && reg_addr == 10'h0F7 |=> reg_rdata[7:5] == 3'h0;
	endproperty
	a_rsv7: assert property (p_rsv7) else $error("rsv7");
	property p_gap;
		gap_q < 6'h20;
	endproperty
	a_gap: assert property (p_gap) else $error("gap");
endmodule : slfrc_top_sva
bind slfrc_top slfrc_top_sva i_slfrc_top_sva (
	.ref_clk                    (ref_clk),
	.rst                        (rst),
	.reg_addr                   (reg_addr),
	.reg_wr                     (reg_wr),
	.reg_rd                     (reg_rd),
	.reg_wdata                  (reg_wdata),
	.reg_rdata                  (reg_rdata),
	.second_pole_resistor       (second_pole_resistor),
	.zero_resistor              (zero_resistor),
	.first_pole_capacitor       (first_pole_capacitor),
	.zero_bypass                (zero_bypass),
	.second_pole_ohms           (second_pole_ohms),
	.zero_ohms                  (zero_ohms),
	.first_pole_pf              (first_pole_pf),
	.synth_ref_predivider_pulse (synth_ref_predivider_pulse)
);
`default_nettype wire

/* File: sim/test_slfrc_top.sv */
// testbench: register access and predivider checks for the loop filter config bank
`timescale 1ns/100ps
`default_nettype none
module test_slfrc_top;
	logic ref_clk, rst, reg_wr, reg_rd, zero_bypass, synth_ref_predivider_pulse;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] second_pole_resistor;
	logic [2:0] zero_resistor, first_pole_capacitor;
	logic [11:0] second_pole_ohms, zero_ohms;
	logic [5:0] first_pole_pf;
	logic [7:0] nv [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h1F};
	logic [11:0] pole_tab [4] = '{12'h384, 12'h1C2, 12'h12C, 12'h0E1};
	logic [11:0] zero_tab [8] = '{12'hCB2, 12'hABE, 12'h8CA, 12'h834,
		12'hBB8, 12'h9C4, 12'h7D0, 12'h73A};
	logic [5:0]  cap_tab  [8] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h18, 6'h20, 6'h28, 6'h30};
	int err_total, checks_done, g;
	slfrc_top i_slfrc_top (
		.ref_clk                    (ref_clk),
		.rst                        (rst),
		.reg_addr                   (reg_addr),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_wdata                  (reg_wdata),
		.reg_rdata                  (reg_rdata),
		.second_pole_resistor       (second_pole_resistor),
		.zero_resistor              (zero_resistor),
		.first_pole_capacitor       (first_pole_capacitor),
		.zero_bypass                (zero_bypass),
		.second_pole_ohms           (second_pole_ohms),
		.zero_ohms                  (zero_ohms),
		.first_pole_pf              (first_pole_pf),
		.synth_ref_predivider_pulse (synth_ref_predivider_pulse)
	);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task stop_test;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [11:0] s, input logic [11:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// returns once decoded outputs have settled
	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : wr
	task rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk("rdata", reg_rdata, e);
	endtask : rd
	// cycles from one pulse to the next, bounded
	task per(output int n);
		int k;
		k = 0;
		@(negedge ref_clk);
		while (synth_ref_predivider_pulse !== 1'b1 && k < 99) begin
			@(negedge ref_clk);
			k++;
		end
		n = 1;
		@(negedge ref_clk);
		while (synth_ref_predivider_pulse !== 1'b1 && n < 99) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : per
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, err_total, checks_done} = '0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd(10'h0F5, 8'h00);
		rd(10'h0F6, 8'h00);
		rd(10'h0F7, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(10'h0F5, {i[1:0], i[2:0], i[2:0]});
			chk("pole", second_pole_resistor, i[1:0]);
			chk("zero", zero_resistor, i[2:0]);
			chk("cap", first_pole_capacitor, i[2:0]);
			chk("pole ohms", second_pole_ohms, pole_tab[i[1:0]]);
			chk("zero ohms", zero_ohms, zero_tab[i[2:0]]);
			chk("cap pf", first_pole_pf, cap_tab[i[2:0]]);
			rd(10'h0F5, {i[1:0], i[2:0], i[2:0]});
		end
		wr(10'h0F6, 8'hFF);
		chk("bypass", zero_bypass, 12'h001);
		chk("zohm", zero_ohms, 12'h000);
		rd(10'h0F6, 8'h01);
		wr(10'h0F6, 8'h00);
		chk("zohm", zero_ohms, 12'h73A);
		wr(10'h0F8, 8'h5A);
		rd(10'h0F8, 8'h00);
		rd(10'h0F4, 8'h00);
		rd(10'h0F5, 8'hFF);
		wr(10'h0F7, 8'hFF);
		rd(10'h0F7, 8'h1F);
		// first periods after a change may still run the old count
		foreach (nv[j]) begin
			wr(10'h0F7, nv[j]);
			per(g);
			per(g);
			per(g);
			chk("period", 12'(g), (nv[j] < 8'h02) ? 12'h001 : {4'h0, nv[j]});
		end
		// mid-run reset: registers and outputs back to zero, divide-by-one
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("rst pole", second_pole_resistor, 12'h000);
		chk("rst zero", zero_resistor, 12'h000);
		chk("rst cap", first_pole_capacitor, 12'h000);
		chk("rst bypass", zero_bypass, 12'h000);
		chk("rst pole ohms", second_pole_ohms, 12'h000);
		chk("rst zero ohms", zero_ohms, 12'h000);
		chk("rst cap pf", first_pole_pf, 12'h000);
		chk("rst pulse", synth_ref_predivider_pulse, 12'h000);
		chk("rst rdata", reg_rdata, 12'h000);
		@(posedge ref_clk);
		rst <= 1'b0;
		rd(10'h0F5, 8'h00);
		rd(10'h0F6, 8'h00);
		rd(10'h0F7, 8'h00);
		per(g);
		per(g);
		chk("period", 12'(g), 12'h001);
		stop_test();
	end
	initial begin
		#500000;
		err_total++;
		stop_test();
	end
endmodule : test_slfrc_top
`default_nettype wire
